// ### design/plcms_pkg.sv
// Types shared by the concealment mode selector files
package plcms_pkg;

  // ****************************************************************
  // Concealment mode codes
  // ****************************************************************
  typedef enum logic [2:0] {
    PLCMS_OLA         = 3'b000,
    PLCMS_PM_ERASED   = 3'b001,
    PLCMS_PM_NEXT     = 3'b010,
    PLCMS_PM_BURST    = 3'b011,
    PLCMS_RS_ERASED   = 3'b100,
    PLCMS_RS_NEXT_ONE = 3'b101,
    PLCMS_RS_NEXT_BST = 3'b110,
    PLCMS_NG_AFTER_BST = 3'b111
  } plcms_mode_e;

  typedef logic [15:0] plcms_energy_t;

endpackage

// ### design/plcms_regs.svh
// Register offsets, reset values and field positions of the concealment mode selector
// Behaviour
// - First loss, armed, no continuation: phase match
// - Bad then good with continuation: next-good phase match
// - Bad then bad with continuation: burst phase match
// - Arming needs peak band within 75-1000 Hz
// - Arming needs band step<=1 and small energy change
// - Arming needs no transient among three past frames
// - Arm flag computed on each good frame update
// - Current stationarity set when difference below 0.032209
// - Hysteresis copies only on agreement, then stores current
// - Stationary erased frame: repetition and smoothing
// - Non-stationary erased frame: conventional overlap-add
// - Stationary next good frame: repetition and smoothing
// - Non-stationary after burst: next-good-after-burst mode
// - Non-stationary after single loss: conventional overlap-add
// - Next-good smoothing has single and burst variants
// - Continuation flag held after phase-matched erasure
`ifndef PLCMS_REGS_SVH
`define PLCMS_REGS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define PLCMS_STAT_THR_OFS   8'h00
`define PLCMS_RS_THR_OFS     8'h04
`define PLCMS_EC_THR_OFS     8'h08
`define PLCMS_BAND_OFS       8'h0C
`define PLCMS_STATUS_OFS     8'h10

// ****************************************************************
// Reset values (energies are unsigned Q0.16 fractions)
// ****************************************************************
`define PLCMS_STAT_THR_RST   16'h083F
`define PLCMS_RS_THR_RST     16'h28B8
`define PLCMS_EC_THR_RST     16'h1000
`define PLCMS_BAND_LO_RST    8'h01
`define PLCMS_BAND_HI_RST    8'h0A

// ****************************************************************
// Field positions
// ****************************************************************
`define PLCMS_BAND_LO_LSB    0
`define PLCMS_BAND_HI_LSB    8
`define PLCMS_ST_MODE_LSB    0
`define PLCMS_ST_ARM_BIT     3
`define PLCMS_ST_NEXT_BIT    4
`define PLCMS_ST_OUT_BIT     5
`define PLCMS_ST_OLD_BIT     6
`define PLCMS_ST_CNT_LSB     8
`define PLCMS_TRANS_DEPTH    3

`endif

// ### design/plcms_selector.sv
// Per-frame concealment mode selector with APB register access
`timescale 1ns/100ps
`default_nettype none
`include "plcms_regs.svh"
module plcms_selector
  import plcms_pkg::*;
#(
  parameter int BAND_W = 8,
  parameter int CNT_W  = 8
)
(
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  // APB slave
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [7:0]               paddr,
  input  wire logic [31:0]              pwdata,
  output logic [31:0]                   prdata,
  output logic                          pready,
  output logic                          pslverr,
  // Frame side
  input  wire logic                     frame_strobe,
  input  wire logic                     bfi_cur,
  input  wire logic                     bfi_prev,
  input  wire plcms_pkg::plcms_energy_t diff_energy,
  input  wire logic [BAND_W-1:0]        max_band_idx,
  input  wire logic                     frame_transient,
  output plcms_pkg::plcms_mode_e        plc_mode,
  output logic                          mode_valid,
  output logic                          pm_arm,
  output logic                          pm_continue,
  output logic [CNT_W-1:0]              lost_frame_count
);
  import plcms_pkg::*;

  // ****************************************************************
  // Storage
  // ****************************************************************
  plcms_energy_t                   stat_thr_q;
  plcms_energy_t                   rs_thr_q;
  plcms_energy_t                   energy_change_threshold_q;
  logic [BAND_W-1:0]               band_lo_q;
  logic [BAND_W-1:0]               band_hi_q;
  plcms_mode_e                     mode_q;
  logic                            valid_q;
  logic                            arm_q;
  logic                            cont_q;
  logic [CNT_W-1:0]                cnt_q;
  logic [BAND_W-1:0]               prev_band_q;
  logic                            band_seen_q;
  logic [`PLCMS_TRANS_DEPTH-1:0]   trans_hist_q;
  plcms_energy_t                   diff_last_q;
  logic [31:0]                     prdata_q;
  logic                            pready_q;
  logic                            pslverr_q;

  logic                            stat_old;
  logic                            stat_out;
  logic                            good_upd;
  logic [CNT_W-1:0]                cnt_now;
  logic                            stationary;
  logic                            band_ok;
  logic                            step_ok;
  logic                            arm_d;
  plcms_mode_e                     mode_d;
  logic                            cont_d;
  logic [BAND_W-1:0]               band_step;
  logic                            setup;
  logic                            wr_en;
  logic                            addr_ok;
  logic [31:0]                     rd_word;

  // ****************************************************************
  // Frame bookkeeping
  // ****************************************************************

  // Good frames run the memory update that refreshes every measure
  assign good_upd = frame_strobe & ~bfi_cur;

  // Loss count including the current frame; saturates instead of wrapping
  always_comb
  begin
    cnt_now = cnt_q;
    if (bfi_cur && (cnt_q != {CNT_W{1'b1}}))
    begin
      cnt_now = cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  // Stationarity of the last good frame, either test suffices
  assign stationary = stat_out | (diff_last_q < rs_thr_q);

  plcms_stat_hyst u_hyst (
    .pclk        (pclk),
    .presetn     (presetn),
    .update      (good_upd),
    .diff_energy (diff_energy),
    .stat_thr    (stat_thr_q),
    .stat_old_q  (stat_old),
    .stat_out_q  (stat_out)
  );

  // ****************************************************************
  // Phase matching arm decision
  // ****************************************************************

  // Band window stands for 75..1000 Hz in sub-band index terms
  assign band_ok = (max_band_idx >= band_lo_q) && (max_band_idx <= band_hi_q);
  assign band_step = (max_band_idx >= prev_band_q) ? (max_band_idx - prev_band_q)
                                                   : (prev_band_q - max_band_idx);
  // First good frame has no history, so it cannot arm
  assign step_ok = band_seen_q && (band_step <= {{(BAND_W-1){1'b0}}, 1'b1});
  assign arm_d = band_ok && step_ok
                 && (diff_energy < energy_change_threshold_q)
                 && (trans_hist_q == '0);

  // Arm flag and history only move on a good frame
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      arm_q        <= 1'b0;
      prev_band_q  <= '0;
      band_seen_q  <= 1'b0;
      trans_hist_q <= '0;
      diff_last_q  <= '0;
    end
    else if (good_upd)
    begin
      arm_q        <= arm_d;
      prev_band_q  <= max_band_idx;
      band_seen_q  <= 1'b1;
      trans_hist_q <= {trans_hist_q[`PLCMS_TRANS_DEPTH-2:0], frame_transient};
      diff_last_q  <= diff_energy;
    end
  end

  // ****************************************************************
  // Mode decision
  // ****************************************************************

  // Priority chain: phase matching first, then smoothing, then overlap-add
  always_comb
  begin
    mode_d = PLCMS_OLA;
    cont_d = cont_q;
    if (bfi_cur && (cnt_now == {{(CNT_W-1){1'b0}}, 1'b1}) && arm_q && !cont_q)
    begin
      mode_d = PLCMS_PM_ERASED;
      cont_d = 1'b1;
    end
    else if (bfi_prev && !bfi_cur && cont_q)
    begin
      mode_d = PLCMS_PM_NEXT;
      cont_d = 1'b0;
    end
    else if (bfi_prev && bfi_cur && cont_q)
    begin
      mode_d = PLCMS_PM_BURST;
    end
    else if (bfi_cur)
    begin
      mode_d = stationary ? PLCMS_RS_ERASED : PLCMS_OLA;
    end
    else if (bfi_prev)
    begin
      if (stationary)
      begin
        // Smoothing variant depends on the burst length
        mode_d = (cnt_q > {{(CNT_W-1){1'b0}}, 1'b1}) ? PLCMS_RS_NEXT_BST
                                                      : PLCMS_RS_NEXT_ONE;
      end
      else
      begin
        mode_d = (cnt_q > {{(CNT_W-1){1'b0}}, 1'b1}) ? PLCMS_NG_AFTER_BST
                                                      : PLCMS_OLA;
      end
    end
    else
    begin
      cont_d = 1'b0;
    end
  end

  // Mode registered once per strobe and held until the next one
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_q  <= PLCMS_OLA;
      cont_q  <= 1'b0;
      cnt_q   <= '0;
      valid_q <= 1'b0;
    end
    else
    begin
      valid_q <= frame_strobe;
      if (frame_strobe)
      begin
        mode_q <= mode_d;
        cont_q <= cont_d;
        cnt_q  <= bfi_cur ? cnt_now : '0;
      end
    end
  end

  // ****************************************************************
  // APB slave: no wait state, answer prepared in setup cycle
  // ****************************************************************
  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pready_q & pwrite;
  assign addr_ok = (paddr == `PLCMS_STAT_THR_OFS) || (paddr == `PLCMS_RS_THR_OFS)
                   || (paddr == `PLCMS_EC_THR_OFS) || (paddr == `PLCMS_BAND_OFS)
                   || (paddr == `PLCMS_STATUS_OFS);

  // Read mux; unmapped addresses read zero
  always_comb
  begin
    rd_word = 32'h0000_0000;
    unique case (paddr)
      `PLCMS_STAT_THR_OFS: rd_word[15:0] = stat_thr_q;
      `PLCMS_RS_THR_OFS:   rd_word[15:0] = rs_thr_q;
      `PLCMS_EC_THR_OFS:   rd_word[15:0] = energy_change_threshold_q;
      `PLCMS_BAND_OFS:
      begin
        rd_word[`PLCMS_BAND_LO_LSB +: BAND_W] = band_lo_q;
        rd_word[`PLCMS_BAND_HI_LSB +: BAND_W] = band_hi_q;
      end
      `PLCMS_STATUS_OFS:
      begin
        rd_word[`PLCMS_ST_MODE_LSB +: 3]     = mode_q;
        rd_word[`PLCMS_ST_ARM_BIT]           = arm_q;
        rd_word[`PLCMS_ST_NEXT_BIT]          = cont_q;
        rd_word[`PLCMS_ST_OUT_BIT]           = stat_out;
        rd_word[`PLCMS_ST_OLD_BIT]           = stat_old;
        rd_word[`PLCMS_ST_CNT_LSB +: CNT_W]  = cnt_q;
      end
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // Handshake flops; pready rises only for the access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end
    else
    begin
      pready_q <= setup;
      if (setup)
      begin
        pslverr_q <= ~addr_ok;
        prdata_q  <= pwrite ? 32'h0000_0000 : rd_word;
      end
    end
  end

  // Writable thresholds; the status word ignores writes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stat_thr_q                <= `PLCMS_STAT_THR_RST;
      rs_thr_q                  <= `PLCMS_RS_THR_RST;
      energy_change_threshold_q <= `PLCMS_EC_THR_RST;
      band_lo_q                 <= BAND_W'(`PLCMS_BAND_LO_RST);
      band_hi_q                 <= BAND_W'(`PLCMS_BAND_HI_RST);
    end
    else if (wr_en)
    begin
      unique case (paddr)
        `PLCMS_STAT_THR_OFS: stat_thr_q <= pwdata[15:0];
        `PLCMS_RS_THR_OFS:   rs_thr_q <= pwdata[15:0];
        `PLCMS_EC_THR_OFS:   energy_change_threshold_q <= pwdata[15:0];
        `PLCMS_BAND_OFS:
        begin
          band_lo_q <= pwdata[`PLCMS_BAND_LO_LSB +: BAND_W];
          band_hi_q <= pwdata[`PLCMS_BAND_HI_LSB +: BAND_W];
        end
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign prdata           = prdata_q;
  assign pready           = pready_q;
  assign pslverr          = pslverr_q;
  assign plc_mode         = mode_q;
  assign mode_valid       = valid_q;
  assign pm_arm           = arm_q;
  assign pm_continue      = cont_q;
  assign lost_frame_count = cnt_q;

endmodule // plcms_selector
`default_nettype wire

// ### design/plcms_stat_hyst.sv
// Stationarity decision with hysteresis for the concealment mode selector
`timescale 1ns/100ps
`default_nettype none
module plcms_stat_hyst
  import plcms_pkg::*;
(
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     update,
  input  wire plcms_pkg::plcms_energy_t diff_energy,
  input  wire plcms_pkg::plcms_energy_t stat_thr,
  output logic                          stat_old_q,
  output logic                          stat_out_q
);
  import plcms_pkg::*;

  logic stat_curr;

  // Current-frame stationarity from the energy difference
  assign stat_curr = (diff_energy < stat_thr);

  // Output follows only when two frames agree, which damps toggling
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stat_old_q <= 1'b0;
      stat_out_q <= 1'b0;
    end
    else if (update)
    begin
      if (stat_old_q == stat_curr)
      begin
        stat_out_q <= stat_curr;
      end
      stat_old_q <= stat_curr;
    end
  end

endmodule // plcms_stat_hyst
`default_nettype wire

// ### test/plc_mode_selector_bench.sv
// Self-checking bench for the concealment mode selector
`timescale 1ns/100ps
`default_nettype none
module plc_mode_selector_bench;
  import plcms_pkg::*;
  logic          pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]    paddr, idx, cnt;
  logic [31:0]   pwdata, prdata;
  logic          strobe, bcur, bprev, trans, mvalid, arm, cont;
  plcms_energy_t diff;
  plcms_mode_e   mode;
  int            miscompares = 0;
  int            total_checks = 0;
  logic [7:0]    ra [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
  logic [31:0]   rv [6] = '{32'h0000_083F, 32'h0000_28B8, 32'h0000_1000, 32'h0000_0A01,
                           32'h0000_0000, 32'h0000_0000};

  // Clock
  initial pclk = 1'b0;
  always #5 pclk = ~pclk;

  plcms_selector i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .frame_strobe(strobe), .bfi_cur(bcur), .bfi_prev(bprev),
    .diff_energy(diff), .max_band_idx(idx), .frame_transient(trans), .plc_mode(mode),
    .mode_valid(mvalid), .pm_arm(arm), .pm_continue(cont), .lost_frame_count(cnt));
  plcms_frame_src i_src (.pclk(pclk), .frame_strobe(strobe), .bfi_cur(bcur),
    .bfi_prev(bprev), .diff_energy(diff), .max_band_idx(idx), .frame_transient(trans));

  // ********************
  // Shared tasks
  // ********************
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // APB transfer; waits for pready as long as it takes, the watchdog ends a hang
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] exp, input logic err);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
    begin
      @(posedge pclk);
    end
    if (!w)
      chk("prdata", exp, prdata);
    chk("pslverr", {31'h0, err}, {31'h0, pslverr});
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Frame and its answer one cycle later
  task automatic frm(input logic c, input logic p, input plcms_energy_t d,
                     input logic [7:0] i, input plcms_mode_e m);
    i_src.send(c, p, d, i, 1'b0);
    #1;
    chk("mode_valid", 32'h1, {31'h0, mvalid});
    chk("plc_mode", {29'h0, m}, {29'h0, mode});
  endtask

  // Good frame, then the arm flag it leaves behind
  task automatic armf(input plcms_energy_t d, input logic [7:0] i, input logic e);
    i_src.send(1'b0, 1'b0, d, i, 1'b0);
    #1;
    chk("pm_arm", {31'h0, e}, {31'h0, arm});
  endtask

  task automatic end_of_test;
    if (miscompares == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Watchdog far beyond the roughly 150 cycles the tests take
  initial
  begin
    #100us;
    miscompares++;
    end_of_test();
  end

  // ********************
  // Test sequence
  // ********************
  initial
  begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    chk("reset outputs", 32'h0, {mode, arm, cont, cnt});
    for (int k = 0; k < 6; k++)
      acc(1'b0, ra[k], 32'h0, rv[k], k == 5);
    acc(1'b1, 8'h00, 32'hFFFF_083F, 32'h0, 1'b0);
    acc(1'b0, 8'h00, 32'h0, 32'h0000_083F, 1'b0);
    acc(1'b1, 8'h10, 32'h0000_00FF, 32'h0, 1'b0);
    acc(1'b0, 8'h10, 32'h0, 32'h0000_0000, 1'b0);
    acc(1'b1, 8'h14, 32'h0000_0001, 32'h0, 1'b1);
    // Arm, then phase matching through a burst
    repeat (4) i_src.send(1'b0, 1'b0, 16'h0100, 8'h05, 1'b0);
    #1;
    chk("pm_arm", 32'h1, {31'h0, arm});
    frm(1'b1, 1'b0, 16'h0100, 8'h05, PLCMS_PM_ERASED);
    chk("pm_continue", 32'h1, {31'h0, cont});
    frm(1'b1, 1'b1, 16'h0100, 8'h05, PLCMS_PM_BURST);
    chk("lost_frame_count", 32'h2, {24'h0, cnt});
    frm(1'b0, 1'b1, 16'h0100, 8'h05, PLCMS_PM_NEXT);
    chk("lost_frame_count", 32'h0, {24'h0, cnt});
    // A transient frame blocks arming; stationary smoothing paths
    i_src.send(1'b0, 1'b0, 16'h0100, 8'h05, 1'b1);
    frm(1'b0, 1'b0, 16'h0100, 8'h05, PLCMS_OLA);
    chk("pm_arm", 32'h0, {31'h0, arm});
    frm(1'b1, 1'b0, 16'h0100, 8'h05, PLCMS_RS_ERASED);
    frm(1'b0, 1'b1, 16'h0100, 8'h05, PLCMS_RS_NEXT_ONE);
    frm(1'b1, 1'b0, 16'h0100, 8'h05, PLCMS_RS_ERASED);
    frm(1'b1, 1'b1, 16'h0100, 8'h05, PLCMS_RS_ERASED);
    frm(1'b0, 1'b1, 16'h0100, 8'h05, PLCMS_RS_NEXT_BST);
    // Hysteresis holds one frame, then the signal turns non-stationary
    i_src.send(1'b0, 1'b0, 16'h3000, 8'h14, 1'b0);
    acc(1'b0, 8'h10, 32'h0, 32'h0000_0020, 1'b0);
    i_src.send(1'b0, 1'b0, 16'h3000, 8'h14, 1'b0);
    acc(1'b0, 8'h10, 32'h0, 32'h0000_0000, 1'b0);
    frm(1'b1, 1'b0, 16'h3000, 8'h14, PLCMS_OLA);
    frm(1'b0, 1'b1, 16'h3000, 8'h14, PLCMS_OLA);
    frm(1'b1, 1'b0, 16'h3000, 8'h14, PLCMS_OLA);
    frm(1'b1, 1'b1, 16'h3000, 8'h14, PLCMS_OLA);
    frm(1'b0, 1'b1, 16'h3000, 8'h14, PLCMS_NG_AFTER_BST);
    // Stationarity threshold at its boundary
    repeat (2) i_src.send(1'b0, 1'b0, 16'h083E, 8'h14, 1'b0);
    acc(1'b0, 8'h10, 32'h0, 32'h0000_0060, 1'b0);
    i_src.send(1'b0, 1'b0, 16'h083F, 8'h14, 1'b0);
    acc(1'b0, 8'h10, 32'h0, 32'h0000_0020, 1'b0);
    // Energy-difference alternative keeps smoothing when hysteresis says no
    i_src.send(1'b0, 1'b0, 16'h2000, 8'h14, 1'b0);
    frm(1'b1, 1'b0, 16'h2000, 8'h14, PLCMS_RS_ERASED);
    frm(1'b0, 1'b1, 16'h2000, 8'h14, PLCMS_RS_NEXT_ONE);
    i_src.send(1'b0, 1'b0, 16'h28B8, 8'h14, 1'b0);
    frm(1'b1, 1'b0, 16'h28B8, 8'h14, PLCMS_OLA);
    frm(1'b0, 1'b1, 16'h28B8, 8'h14, PLCMS_OLA);
    // Arming window, band step and energy change one at a time
    armf(16'h0100, 8'h05, 1'b0);
    armf(16'h0100, 8'h05, 1'b1);
    armf(16'h0100, 8'h07, 1'b0);
    armf(16'h1000, 8'h07, 1'b0);
    armf(16'h0FFF, 8'h07, 1'b1);
    armf(16'h0100, 8'h08, 1'b1);
    armf(16'h0100, 8'h09, 1'b1);
    armf(16'h0100, 8'h0A, 1'b1);
    armf(16'h0100, 8'h0B, 1'b0);
    acc(1'b1, 8'h0C, 32'h0000_0C0B, 32'h0, 1'b0);
    armf(16'h0100, 8'h0B, 1'b1);
    armf(16'h0100, 8'h0A, 1'b0);
    end_of_test();
  end
endmodule // plc_mode_selector_bench
`default_nettype wire

// ### test/plcms_frame_src.sv
// Decoder pipeline model that presents one frame per strobe
`timescale 1ns/100ps
`default_nettype none
module plcms_frame_src
  import plcms_pkg::*;
(
  input  wire logic                pclk,
  output logic                     frame_strobe,
  output logic                     bfi_cur,
  output logic                     bfi_prev,
  output plcms_pkg::plcms_energy_t diff_energy,
  output logic [7:0]               max_band_idx,
  output logic                     frame_transient
);
  import plcms_pkg::*;

  // Quiet lines at time zero
  initial
  begin
    {frame_strobe, bfi_cur, bfi_prev, frame_transient} = 4'h0;
    diff_energy = 16'h0000;
    max_band_idx = 8'h00;
  end

  // One frame: strobe with its flags, then stale values turned round
  task automatic send(input logic c, input logic p, input plcms_energy_t d,
                      input logic [7:0] i, input logic t);
    @(posedge pclk);
    frame_strobe <= 1'b1;
    {bfi_cur, bfi_prev} <= {c, p};
    diff_energy <= d;
    max_band_idx <= i;
    frame_transient <= t;
    @(posedge pclk);
    frame_strobe <= 1'b0;
    {bfi_cur, bfi_prev, frame_transient} <= ~{c, p, t}; // Nothing may lean on them now
    diff_energy <= ~d;
    max_band_idx <= ~i;
  endtask
endmodule // plcms_frame_src
`default_nettype wire

// ### test/plcms_selector_assertions.sv
// Frame-side temporal checks for the concealment mode selector
`timescale 1ns/100ps
`default_nettype none
module plcms_selector_assertions
  import plcms_pkg::*;
#(
  parameter int BAND_W = 8,
  parameter int CNT_W  = 8
)
(
  input wire logic                   pclk,
  input wire logic                   presetn,
  input wire logic                   frame_strobe,
  input wire logic                   bfi_cur,
  input wire logic                   bfi_prev,
  input wire plcms_pkg::plcms_mode_e plc_mode,
  input wire logic                   mode_valid,
  input wire logic                   pm_arm,
  input wire logic                   pm_continue,
  input wire logic [CNT_W-1:0]       lost_frame_count
);
  import plcms_pkg::*;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // ********************
  // Frame decision steps
  // ********************
  sequence s_pm_start;
    frame_strobe && bfi_cur && !bfi_prev && pm_arm && !pm_continue;
  endsequence
  sequence s_burst_cont;
    frame_strobe && bfi_cur && bfi_prev && pm_continue;
  endsequence
  sequence s_recover_cont;
    frame_strobe && !bfi_cur && bfi_prev && pm_continue;
  endsequence

  // One answer per strobe, code held in between
  a_valid_after_strobe: assert property (frame_strobe |=> mode_valid)
    else $error("mode_valid missing after strobe");
  a_valid_has_cause: assert property (mode_valid |-> $past(frame_strobe))
    else $error("mode_valid without strobe");
  a_mode_held: assert property (!frame_strobe |=> $stable(plc_mode))
    else $error("plc_mode changed without strobe");
  // Phase matching precedence and continuation
  a_first_loss_pm: assert property (
    s_pm_start |=> plc_mode == PLCMS_PM_ERASED && pm_continue)
    else $error("armed first loss not phase matched");
  a_burst_pm: assert property (
    s_burst_cont |=> plc_mode == PLCMS_PM_BURST && pm_continue)
    else $error("burst with continuation not phase matched");
  a_next_good_pm: assert property (s_recover_cont |=> plc_mode == PLCMS_PM_NEXT)
    else $error("recovery with continuation not phase matched");
  a_pm_one_loss: assert property (
    mode_valid && plc_mode == PLCMS_PM_ERASED |-> lost_frame_count == 1)
    else $error("erased phase match with loss count not one");
  // Arm flag only moves on good frames
  a_arm_kept_loss: assert property (frame_strobe && bfi_cur |=> $stable(pm_arm))
    else $error("pm_arm changed on a lost frame");
  // Loss counter steps and clears
  a_count_step: assert property (frame_strobe && bfi_cur && !(&lost_frame_count)
    |=> lost_frame_count == $past(lost_frame_count) + 1'b1)
    else $error("loss count did not step");
  a_count_clear: assert property (frame_strobe && !bfi_cur |=> lost_frame_count == '0)
    else $error("loss count not cleared on good frame");
endmodule // plcms_selector_assertions

bind plcms_selector plcms_selector_assertions #(.BAND_W(BAND_W), .CNT_W(CNT_W)) i_chk (
  .pclk(pclk), .presetn(presetn), .frame_strobe(frame_strobe), .bfi_cur(bfi_cur),
  .bfi_prev(bfi_prev), .plc_mode(plc_mode), .mode_valid(mode_valid), .pm_arm(pm_arm),
  .pm_continue(pm_continue), .lost_frame_count(lost_frame_count));
`default_nettype wire
